//--- verilog/lhp_host_port.sv
/*
  Host control port: mode decode, serial port, parallel port, strap
  decode, interrupt pin and receive clock inversion.
  Assumes a register bank on i_clk_sys that answers o_rd_addr with
  i_rd_data in the same cycle, and pads that resolve the three-state
  and open-drain pins from the _o/_oe pairs.
*/
`timescale 1ns/10ps
module lhp_host_port (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_nrst,
  input  wire logic                 i_ce,
  input  wire logic                 i_sclk,
  input  wire lhp_pkg::lhp_pins_t   i_pins,
  input  wire logic                 i_part_120,
  input  wire logic [7:0]           i_rx_clock_invert_reg,
  input  wire logic                 i_irq_active,
  input  wire logic                 i_irq_drive_high,
  input  wire logic                 i_soft_reset,
  input  wire logic                 i_irq_rearm,
  input  wire logic [7:0]           i_rd_data,
  output lhp_pkg::lhp_mode_t        o_mode,
  output lhp_pkg::lhp_hw_cfg_t      o_hw_cfg,
  output lhp_pkg::lhp_wr_t          o_wr,
  output logic [4:0]                o_rd_addr,
  output logic [7:0]                o_rx_clk_inv,
  output logic                      o_irq_n_o,
  output logic                      o_irq_n_oe,
  output logic [7:0]                o_bus_o,
  output logic                      o_bus_oe,
  output logic                      o_hs_o,
  output logic                      o_hs_oe
);
  import lhp_pkg::*;

  // System-domain state
  typedef struct packed {
    lhp_pins_t   p1;       // First sync stage, read only by p2
    lhp_pins_t   p2;       // Second sync stage
    logic        sc1;      // Latch-enable / strobe sync
    logic        sc2;
    logic        sc3;      // Previous value for edge detect
    logic        wt1;      // Serial write toggle sync
    logic        wt2;
    logic        wt3;
    logic        rt1;      // Serial read toggle sync
    logic        rt2;
    logic        rt3;
    lhp_mode_t   mode;
    lhp_hw_cfg_t cfg;
    logic [7:0]  inv;
    lhp_pst_t    pst;
    logic        is_rd;    // Current parallel cycle is a read
    logic [4:0]  lat_addr; // Address caught from shared bus
    logic [4:0]  rd_addr;
    logic [7:0]  wdata;
    lhp_wr_t     wr;
    logic [7:0]  bus_o;
    logic        bus_oe;
    logic        hs;       // Ready or acknowledge level
    logic        hs_oe;
    logic        armed;    // Interrupt sources enabled
    logic        irq_o;
    logic        irq_oe;
    logic        srd_pend;
    logic [7:0]  srd_word; // Serial read word, held for shifting
  } lhp_sys_t;

  // Serial-domain frame state, cleared by chip select
  typedef struct packed {
    logic [4:0] cnt;
    logic [7:0] cmd;
    logic [7:0] wdat;
    logic       rd;
    logic       dph;       // Read data phase
    logic       pos_q;     // Bit launched on rising edge
  } lhp_ser_t;

  // Serial-domain crossing holds, kept across frames
  typedef struct packed {
    logic       wtog;
    logic       rtog;
    logic [4:0] addr;
    logic [7:0] wdata;
  } lhp_hold_t;

  lhp_sys_t  q;            // System state
  lhp_sys_t  n;            // Next system state
  lhp_ser_t  sq;           // Serial state
  lhp_ser_t  sn;
  lhp_hold_t hq;           // Crossing holds
  lhp_hold_t hn;
  logic      neg_q;        // Bit launched on falling edge
  logic      cs_n_raw;     // Chip select pin as async clear
  logic      sdi;          // Serial input pin
  logic [15:0] loop_dec;   // Decoded loopback codes
  logic      cs_n;
  logic      strobe;
  logic      rd_req;
  logic      ale_fall;
  logic      sdo;

  assign cs_n_raw = i_pins.cs_lvl[1];
  assign sdi      = i_pins.wr_ts0;

  for (genvar c = 0; c < LHP_CH_N; c++) begin : g_loop
    assign loop_dec[2*c+1:2*c] = (q.p2.loop_lvl[2*c+1:2*c] == LHP_LVL_HIGH) ? LHP_LVL_HIGH :
                                 (q.p2.loop_lvl[2*c+1:2*c] == LHP_LVL_LOW)  ? LHP_LVL_LOW  :
                                 LHP_LVL_MID;
  end

  // Parallel decode of synced pins
  always_comb begin
    cs_n     = q.p2.cs_lvl[1];
    strobe   = !cs_n && (q.p2.style_code ? (!q.p2.rd_ts1 || !q.p2.wr_ts0) : !q.p2.wr_ts0);
    rd_req   = q.p2.style_code ? !q.p2.rd_ts1 : q.p2.rd_ts1;
    ale_fall = q.sc3 && !q.sc2;
  end

  // System next-state logic
  always_comb begin
    n          = q;
    n.wr.valid = 1'b0;
    n.p1       = i_pins;
    n.p2       = q.p1;
    n.sc1      = i_sclk;
    n.sc2      = q.sc1;
    n.sc3      = q.sc2;
    n.wt1      = hq.wtog;
    n.wt2      = q.wt1;
    n.wt3      = q.wt2;
    n.rt1      = hq.rtog;
    n.rt2      = q.rt1;
    n.rt3      = q.rt2;
    case (q.p2.mode_lvl)
      LHP_LVL_MID:  n.mode = LHP_MODE_SER;
      LHP_LVL_HIGH: n.mode = LHP_MODE_PAR;
      default:      n.mode = LHP_MODE_HW;
    endcase
    n.inv = q.p2.edge_sel ? LHP_INV_ALL : i_rx_clock_invert_reg;
    if (i_soft_reset) begin
      n.armed = 1'b0;
    end else if (i_irq_rearm) begin
      n.armed = 1'b1;
    end
    n.irq_o  = !(q.armed && i_irq_active);
    n.irq_oe = (q.armed && i_irq_active) || i_irq_drive_high;
    // Straps only mean something in hardware mode
    if (q.mode == LHP_MODE_HW) begin
      n.cfg.term_alt     = q.p2.mux_term ^ i_part_120;
      n.cfg.code_ami     = q.p2.style_code;
      n.cfg.ja_mode      = (q.p2.cs_lvl == LHP_LVL_HIGH) ? LHP_LVL_HIGH :
                           (q.p2.cs_lvl == LHP_LVL_LOW) ? LHP_LVL_LOW : LHP_LVL_MID;
      n.cfg.rx_match_off = q.p2.rx_off;
      n.cfg.template_sel = {q.sc2, q.p2.rd_ts1, q.p2.wr_ts0};
      n.cfg.loopback     = loop_dec;
    end
    // Serial side, completed in the system domain
    if (q.mode == LHP_MODE_SER) begin
      if (q.wt2 ^ q.wt3) begin
        n.wr = '{valid: 1'b1, addr: hq.addr, data: hq.wdata};
      end
      if (q.rt2 ^ q.rt3) begin
        n.rd_addr  = hq.addr;
        n.srd_pend = 1'b1;
      end else if (q.srd_pend) begin
        n.srd_word = i_rd_data;
        n.srd_pend = 1'b0;
      end
    end
    if (q.mode == LHP_MODE_PAR) begin
      n.hs_oe = !cs_n;
      if (q.p2.mux_term && ale_fall) begin
        n.lat_addr = q.p2.bus[4:0];
      end
      case (q.pst)
        LHP_P_IDLE: begin
          if (strobe) begin
            n.rd_addr = q.p2.mux_term ? q.lat_addr : q.p2.addr;
            n.is_rd   = rd_req;
            n.hs      = !q.p2.style_code;
            n.pst     = LHP_P_ACT;
          end
        end
        LHP_P_ACT: begin
          // Read data driven after strobe fall
          n.bus_o  = i_rd_data;
          n.bus_oe = q.is_rd;
          n.wdata  = q.p2.bus;
          n.hs     = q.p2.style_code;
          n.pst    = LHP_P_HOLD;
        end
        LHP_P_HOLD: begin
          if (strobe) begin
            n.bus_o = i_rd_data;
            n.wdata = q.p2.bus;
          end else begin
            if (!q.is_rd) begin
              n.wr = '{valid: 1'b1, addr: q.rd_addr, data: q.wdata};
            end
            n.bus_oe = 1'b0;
            n.hs     = LHP_HS_IDLE;
            n.pst    = LHP_P_IDLE;
          end
        end
        default: n.pst = LHP_P_IDLE;
      endcase
    end else begin
      n.bus_oe = 1'b0;
      n.hs_oe  = 1'b0;
      n.hs     = LHP_HS_IDLE;
      n.pst    = LHP_P_IDLE;
    end
  end

  // System register, synchronous reset, frozen by clock enable
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      q        <= '0;
      q.hs     <= LHP_HS_IDLE;
      q.irq_o  <= 1'b1;
      q.armed  <= LHP_ARM_RST;
      q.mode   <= LHP_MODE_HW;
      q.pst    <= LHP_P_IDLE;
    end else if (i_ce) begin
      q <= n;
    end
  end

  // Serial frame next state
  always_comb begin
    sn = sq;
    hn = hq;
    if (sq.cnt != LHP_FRAME_END) begin
      sn.cnt = sq.cnt + 5'h01;
    end
    if (sq.cnt <= LHP_CMD_LAST) begin
      sn.cmd[sq.cnt[2:0]] = sdi;
    end else if (sq.cnt <= LHP_FRAME_LAST) begin
      sn.wdat[sq.cnt[2:0]] = sdi;
    end
    if (sq.cnt == LHP_CMD_LAST) begin
      sn.rd  = sq.cmd[0];
      sn.dph = sq.cmd[0];
      if (sq.cmd[0]) begin
        hn.addr = sq.cmd[5:1];
        hn.rtog = !hq.rtog;
      end
    end
    if (sq.cnt == LHP_FRAME_LAST && !sq.rd) begin
      hn.addr  = sq.cmd[5:1];
      hn.wdata = {sdi, sq.wdat[6:0]};
      hn.wtog  = !hq.wtog;
    end
    if (sq.dph && sq.cnt >= LHP_DATA_FIRST && sq.cnt <= LHP_FRAME_LAST) begin
      sn.pos_q = q.srd_word[sq.cnt[2:0]];
    end
  end

  // Chip select high clears the frame
  always_ff @(posedge i_sclk or posedge cs_n_raw) begin
    if (cs_n_raw) begin
      sq <= '0;
    end else begin
      sq <= sn;
    end
  end

  // Crossing holds survive chip select so toggles never glitch
  always_ff @(posedge i_sclk or negedge i_nrst) begin
    if (!i_nrst) begin
      hq <= '0;
    end else if (!cs_n_raw) begin
      hq <= hn;
    end
  end

  always_ff @(negedge i_sclk or posedge cs_n_raw) begin
    if (cs_n_raw) begin
      neg_q <= 1'b0;
    end else if (sq.dph && sq.cnt != LHP_DATA_FIRST) begin
      neg_q <= q.srd_word[sq.cnt[2:0] - 3'h1];
    end
  end

  assign sdo = q.p2.edge_sel ? neg_q : sq.pos_q;

  // Outputs; the shared pin picks its source by mode
  assign o_mode       = q.mode;
  assign o_hw_cfg     = q.cfg;
  assign o_wr         = q.wr;
  assign o_rd_addr    = q.rd_addr;
  assign o_rx_clk_inv = q.inv;
  assign o_irq_n_o    = q.irq_o;
  assign o_irq_n_oe   = q.irq_oe;
  assign o_bus_o      = q.bus_o;
  assign o_bus_oe     = q.bus_oe;
  assign o_hs_o       = (q.mode == LHP_MODE_SER) ? sdo : q.hs;
  // Serial output floats with chip select high
  assign o_hs_oe      = (q.mode == LHP_MODE_SER) ? (sq.dph && !cs_n_raw) : q.hs_oe;

  // Checks
  chk_mode_par_sel: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    i_ce && q.p2.mode_lvl == LHP_LVL_HIGH |=> o_mode == LHP_MODE_PAR)
    else $error("parallel mode not selected");
  chk_irq_low_drive: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    i_ce && q.armed && i_irq_active |=> o_irq_n_oe && !o_irq_n_o)
    else $error("interrupt not driven low");
  chk_soft_disarm: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    i_ce && i_soft_reset ##1 i_ce |=> !o_irq_n_oe || o_irq_n_o)
    else $error("interrupt low after soft reset");
  chk_rx_invert_all: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    i_ce && q.p2.edge_sel |=> o_rx_clk_inv == LHP_INV_ALL)
    else $error("receive clocks not all inverted");
  chk_ready_wait: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    i_ce && q.mode == LHP_MODE_PAR && q.pst == LHP_P_IDLE && strobe && q.p2.style_code
    ##1 i_ce |-> !o_hs_o ##1 o_hs_o)
    else $error("ready did not pulse low then high");
  chk_ack_low: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    i_ce && q.mode == LHP_MODE_PAR && q.pst == LHP_P_ACT && !q.p2.style_code
    |=> !o_hs_o)
    else $error("acknowledge not low");
  chk_par_wr_commit: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    i_ce && q.mode == LHP_MODE_PAR && q.pst == LHP_P_HOLD && !strobe && !q.is_rd
    |=> o_wr.valid && o_wr.data == $past(q.wdata))
    else $error("write not committed on strobe rise");
  chk_mux_addr_latch: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    i_ce && q.mode == LHP_MODE_PAR && q.p2.mux_term && ale_fall
    |=> q.lat_addr == $past(q.p2.bus[4:0]))
    else $error("multiplexed address not latched");
  chk_ser_wr_sync: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    i_ce && q.mode == LHP_MODE_SER && (q.wt2 ^ q.wt3) |=> o_wr.valid && o_wr.addr == hq.addr)
    else $error("serial write not resynchronised");
  chk_sdo_float_cmd: assert property (@(posedge i_sclk) disable iff (cs_n_raw)
    sq.cnt <= LHP_CMD_LAST |-> !sq.dph)
    else $error("serial output driven during command");
  chk_sdi_lsb_first: assert property (@(posedge i_sclk) disable iff (cs_n_raw)
    sq.cnt == 5'h00 |=> sq.cmd[0] == $past(sdi))
    else $error("first serial bit not stored as LSB");
  chk_sdo_rise_bit: assert property (@(posedge i_sclk) disable iff (cs_n_raw)
    sq.dph && sq.cnt == LHP_DATA_FIRST |=> sq.pos_q == $past(q.srd_word[0]))
    else $error("first read bit not LSB");

  cov_par_read: cover property (@(posedge i_clk_sys) disable iff (!i_nrst)
    q.pst == LHP_P_ACT && q.is_rd ##1 o_bus_oe);
  cov_par_write: cover property (@(posedge i_clk_sys) disable iff (!i_nrst)
    q.mode == LHP_MODE_PAR && o_wr.valid);
  cov_ser_write: cover property (@(posedge i_clk_sys) disable iff (!i_nrst)
    q.mode == LHP_MODE_SER && o_wr.valid);
  cov_ser_read: cover property (@(posedge i_sclk) disable iff (cs_n_raw)
    sq.dph && sq.cnt == LHP_FRAME_LAST);
endmodule

//--- common/lhp_pkg.sv
/*
  Shared constants and types for the line-interface host control port.
  Assumes three-level pads arrive already decoded by a pad comparator
  into a two-bit level code, and all other pins as plain logic levels.
*/
package lhp_pkg;
  // Three-level pad comparator codes
  localparam logic [1:0] LHP_LVL_LOW    = 2'h0;
  localparam logic [1:0] LHP_LVL_MID    = 2'h1;
  localparam logic [1:0] LHP_LVL_HIGH   = 2'h2;
  // Channel count and widths
  localparam int         LHP_CH_N       = 8;
  localparam int         LHP_ADDR_W     = 5;
  localparam int         LHP_DATA_W     = 8;
  // Serial frame bit positions
  localparam logic [4:0] LHP_CMD_LAST   = 5'h07;
  localparam logic [4:0] LHP_DATA_FIRST = 5'h08;
  localparam logic [4:0] LHP_FRAME_LAST = 5'h0F;
  localparam logic [4:0] LHP_FRAME_END  = 5'h10;
  // Fixed values
  localparam logic [7:0] LHP_INV_ALL    = 8'hFF;
  localparam logic       LHP_HS_IDLE    = 1'b1;
  localparam logic       LHP_ARM_RST    = 1'b0;

  // Control mode selected by the three-level mode pin
  typedef enum logic [1:0] {LHP_MODE_HW, LHP_MODE_SER, LHP_MODE_PAR} lhp_mode_t;
  // Parallel cycle states
  typedef enum logic [1:0] {LHP_P_IDLE, LHP_P_ACT, LHP_P_HOLD} lhp_pst_t;

  // Hardware-mode strap decode
  typedef struct packed {
    logic        term_alt;
    logic        code_ami;
    logic [1:0]  ja_mode;
    logic        rx_match_off;
    logic [2:0]  template_sel;
    logic [15:0] loopback;
  } lhp_hw_cfg_t;

  // Register write towards the register bank
  typedef struct packed {
    logic       valid;
    logic [4:0] addr;
    logic [7:0] data;
  } lhp_wr_t;

  // Asynchronous pins sampled in the system clock domain
  typedef struct packed {
    logic [1:0]  mode_lvl;
    logic        mux_term;
    logic        style_code;
    logic [1:0]  cs_lvl;
    logic        rd_ts1;
    logic        wr_ts0;
    logic        rx_off;
    logic [7:0]  bus;
    logic [15:0] loop_lvl;
    logic [4:0]  addr;
    logic        edge_sel;
  } lhp_pins_t;
endpackage

//--- tb/lhp_host_model.sv
/*
  Host processor model for the host control port: drives all host pins,
  runs serial frames and parallel cycles through tasks.
  Assumes the bench reads the ready/ack/serial-out pin as a pad value.
*/
`timescale 1ns/10ps
module lhp_host_model
  import lhp_pkg::*;
(
  input  wire logic          i_clk_sys,
  input  wire logic          i_hs_o,
  input  wire logic          i_hs_oe,
  input  wire logic [7:0]    i_bus_o,
  input  wire logic          i_bus_oe,
  output lhp_pkg::lhp_pins_t o_pins,
  output logic               o_sclk
);
  logic hs_w;  // Pad level seen by the host, floats when not driven

  assign hs_w = i_hs_oe ? i_hs_o : 1'bz;

  // Idle pins: chip select high, strobes high, loopback straps mid
  initial begin
    o_sclk = 1'b0;
    o_pins = '{2'h0, 1'b0, 1'b0, LHP_LVL_HIGH, 1'b1, 1'b1, 1'b0, 8'h00,
               16'h5555, 5'h00, 1'b0};
  end

  // Serial frame of n bits; ferr counts output drive where it must float
  task automatic ser(input logic [15:0] f, input int n, output logic [7:0] rb,
                     output int ferr);
    ferr = 0;
    rb = 'x;
    @(posedge i_clk_sys) #1;
    o_sclk = 1'b0;
    o_pins.cs_lvl = LHP_LVL_LOW;
    #50;
    for (int i = 0; i < n; i++) begin
      // Device needs time to fetch read data after the command byte
      if (i == 8) #800;
      o_pins.wr_ts0 = f[i];
      #6;
      if ((i < 8 || !f[0]) && i_hs_oe) ferr++;
      o_sclk = 1'b1;
      #6;
      o_sclk = 1'b0;
      if (i >= 8 && f[0]) begin
        // Falling-edge launch needs a later look
        if (o_pins.edge_sel) #5;
        rb[i-8] = hs_w;
      end
    end
    #20;
    o_pins.cs_lvl = LHP_LVL_HIGH;
    o_pins.wr_ts0 = ~o_pins.wr_ts0;
    #5;
    if (i_hs_oe) ferr++;
    #1100;
  endtask

  // Parallel cycle in the bus style and sharing set on the pins
  task automatic par(input logic rd, input logic [4:0] a, input logic [7:0] wd,
                     output logic [7:0] rdat, output int hs_bad);
    logic mx;
    logic st;
    int   k;
    mx = o_pins.mux_term;
    st = o_pins.style_code;
    rdat = 'x;
    k = 0;
    @(posedge i_clk_sys) #1;
    // Strobes idle first: a serial frame may have left the data line low
    o_pins.rd_ts1 = 1'b1;
    o_pins.wr_ts0 = 1'b1;
    // select low, top two lines high, line 5 and unused address pins grounded
    o_pins.cs_lvl = LHP_LVL_LOW;
    o_pins.bus = {2'h3, 1'b0, a};
    o_pins.addr = mx ? 5'h00 : a;
    o_sclk = 1'b1;
    repeat (3) @(posedge i_clk_sys);
    #1;
    // latch falls when shared, tied high otherwise
    o_sclk = !mx;
    // Address held one more clock so the synced latch edge still sees it
    @(posedge i_clk_sys) #1;
    o_pins.bus = rd ? ~o_pins.bus : wd;
    @(posedge i_clk_sys) #1;
    // strobe or direction plus data strobe
    if (st) begin
      o_pins.rd_ts1 = !rd;
      o_pins.wr_ts0 = rd;
    end else begin
      o_pins.rd_ts1 = rd;
      o_pins.wr_ts0 = 1'b0;
    end
    while (hs_w !== 1'b0 && k < 20) begin
      @(posedge i_clk_sys) #1;
      k++;
    end
    // Ready style must also come back high before the host proceeds
    while (st && hs_w !== 1'b1 && k < 20) begin
      @(posedge i_clk_sys) #1;
      k++;
    end
    hs_bad = (k >= 20);
    @(posedge i_clk_sys) #1;
    if (i_bus_oe) rdat = i_bus_o;
    o_pins.rd_ts1 = 1'b1;
    o_pins.wr_ts0 = 1'b1;
    // Data held past the strobe so the synced sample still sees it
    repeat (3) @(posedge i_clk_sys);
    #1;
    o_pins.cs_lvl = LHP_LVL_HIGH;
    o_pins.bus = ~o_pins.bus;
    repeat (4) @(posedge i_clk_sys);
  endtask
endmodule

//--- tb/lhp_host_port_tb.sv
/*
  Self-checking bench for the host control port: interrupt pin, mode
  decode, straps, serial and parallel accesses.
  Assumes the host model drives every host pin; bank data is {5h, addr}.
*/
`timescale 1ns/10ps
`define HM lhp_host_model_inst
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module lhp_host_port_tb;
  import lhp_pkg::*;
  logic        i_clk_sys = 1'b0;
  logic        i_nrst;
  logic        i_ce;
  logic        i_sclk;
  lhp_pins_t   i_pins;
  logic        i_part_120;
  logic [7:0]  i_rx_clock_invert_reg;
  logic        i_irq_active;
  logic        i_irq_drive_high;
  logic        i_soft_reset;
  logic        i_irq_rearm;
  logic [7:0]  i_rd_data;
  lhp_mode_t   o_mode;
  lhp_hw_cfg_t o_hw_cfg;
  lhp_wr_t     o_wr;
  lhp_wr_t     wr_last;      // Last write pulse seen
  logic [4:0]  o_rd_addr;
  logic [7:0]  o_rx_clk_inv;
  logic        o_irq_n_o;
  logic        o_irq_n_oe;
  logic [7:0]  o_bus_o;
  logic        o_bus_oe;
  logic        o_hs_o;
  logic        o_hs_oe;
  int          failures = 0;
  int          n_checks = 0;
  int          wr_cnt = 0;   // Write pulses seen

  always #50 i_clk_sys = ~i_clk_sys;
  // Register bank answers in the same cycle
  assign i_rd_data = {3'h5, o_rd_addr};

  // Pulse is registered, so it is steady at the falling edge
  always @(negedge i_clk_sys) begin
    if (o_wr.valid === 1'b1) begin
      wr_cnt++;
      wr_last = o_wr;
    end
  end

  lhp_host_port lhp_host_port_inst (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
    .i_ce(i_ce), .i_sclk(i_sclk), .i_pins(i_pins), .i_part_120(i_part_120),
    .i_rx_clock_invert_reg(i_rx_clock_invert_reg), .i_irq_active(i_irq_active),
    .i_irq_drive_high(i_irq_drive_high), .i_soft_reset(i_soft_reset),
    .i_irq_rearm(i_irq_rearm), .i_rd_data(i_rd_data), .o_mode(o_mode),
    .o_hw_cfg(o_hw_cfg), .o_wr(o_wr), .o_rd_addr(o_rd_addr),
    .o_rx_clk_inv(o_rx_clk_inv), .o_irq_n_o(o_irq_n_o), .o_irq_n_oe(o_irq_n_oe),
    .o_bus_o(o_bus_o), .o_bus_oe(o_bus_oe), .o_hs_o(o_hs_o), .o_hs_oe(o_hs_oe));

  lhp_host_model lhp_host_model_inst (.i_clk_sys(i_clk_sys), .i_hs_o(o_hs_o),
    .i_hs_oe(o_hs_oe), .i_bus_o(o_bus_o), .i_bus_oe(o_bus_oe), .o_pins(i_pins),
    .o_sclk(i_sclk));

  // Inputs change just after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask

  task automatic finish_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Whole run is well under 100 us; past 500 us it is a hang
  initial begin
    #500000;
    failures++;
    finish_test();
  end

  initial begin
    logic [7:0] rb;
    logic [4:0] a;
    logic [7:0] d;
    int         fe;
    int         n0;
    i_nrst = 1'b0;
    i_ce = 1'b1;
    i_part_120 = 1'b0;
    i_rx_clock_invert_reg = 8'h5A;
    i_irq_active = 1'b0;
    i_irq_drive_high = 1'b0;
    i_soft_reset = 1'b0;
    i_irq_rearm = 1'b0;
    cyc(10);
    i_nrst = 1'b1;
    cyc(6);
    // Interrupt pin: disarmed after reset, armed, idle drive, soft reset
    i_irq_active = 1'b1;
    cyc(3);
    `CHK(o_irq_n_oe, 1'b0)
    i_irq_rearm = 1'b1;
    cyc(1);
    i_irq_rearm = 1'b0;
    cyc(3);
    `CHK({o_irq_n_oe, o_irq_n_o}, 2'h2)
    i_irq_active = 1'b0;
    cyc(3);
    `CHK(o_irq_n_oe, 1'b0)
    i_irq_drive_high = 1'b1;
    cyc(3);
    `CHK({o_irq_n_oe, o_irq_n_o}, 2'h3)
    i_irq_drive_high = 1'b0;
    i_soft_reset = 1'b1;
    cyc(1);
    i_soft_reset = 1'b0;
    i_irq_active = 1'b1;
    cyc(3);
    `CHK(o_irq_n_oe, 1'b0)
    $display("test irq done");
    // Every level of the mode pin
    for (int m = 0; m < 3; m++) begin
      `HM.o_pins.mode_lvl = 2'(m);
      cyc(4);
      `CHK(o_mode, lhp_mode_t'(m))
    end
    // Clock enable low freezes the mode although the pin moves
    i_ce = 1'b0;
    `HM.o_pins.mode_lvl = LHP_LVL_LOW;
    cyc(4);
    `CHK(o_mode, LHP_MODE_PAR)
    i_ce = 1'b1;
    cyc(4);
    `CHK(o_mode, LHP_MODE_HW)
    $display("test mode done");
    // Straps in hardware mode, two opposite settings
    `HM.o_pins.mode_lvl = LHP_LVL_LOW;
    for (int r = 0; r < 2; r++) begin
      i_part_120 = r[0];
      `HM.o_sclk = !r[0];
      `HM.o_pins = r ? '{2'h0, 1'b1, 1'b0, 2'h1, 1'b1, 1'b0, 1'b0, 8'h00,
                         16'h6A95, 5'h00, 1'b0}
                     : '{2'h0, 1'b1, 1'b1, 2'h2, 1'b0, 1'b1, 1'b1, 8'h00,
                         16'h0009, 5'h00, 1'b1};
      cyc(5);
      `CHK(o_hw_cfg.term_alt, !r[0])
      `CHK(o_hw_cfg.code_ami, !r[0])
      `CHK(o_hw_cfg.ja_mode, r ? LHP_LVL_MID : LHP_LVL_HIGH)
      `CHK(o_hw_cfg.loopback, r ? 16'h6A95 : 16'h0009)
      `CHK({o_hw_cfg.rx_match_off, o_hw_cfg.template_sel}, r ? 4'h2 : 4'hD)
      `CHK(o_rx_clk_inv, r ? i_rx_clock_invert_reg : LHP_INV_ALL)
    end
    $display("test straps done");
    // Serial: write, aborted write, read with both launch edges
    `HM.o_pins.cs_lvl = LHP_LVL_HIGH;
    `HM.o_pins.mode_lvl = LHP_LVL_MID;
    cyc(5);
    `HM.ser({8'hC5, 2'h3, 5'h16, 1'b0}, 16, rb, fe);
    `CHK(wr_last, lhp_wr_t'{1'b1, 5'h16, 8'hC5})
    `CHK(fe, 0)
    n0 = wr_cnt;
    `HM.ser({8'h3C, 2'h0, 5'h09, 1'b0}, 12, rb, fe);
    `CHK(wr_cnt, n0)
    for (int e = 0; e < 2; e++) begin
      a = 5'h0B + 5'(e);
      `HM.o_pins.edge_sel = e[0];
      cyc(4);
      `HM.ser({8'hA5, 2'h3, a, 1'b1}, 16, rb, fe);
      `CHK(rb, {3'h5, a})
      `CHK(fe, 0)
    end
    $display("test serial done");
    // Parallel: every bus style with and without shared address/data
    `HM.o_sclk = 1'b1;
    `HM.o_pins.mode_lvl = LHP_LVL_HIGH;
    for (int i = 0; i < 4; i++) begin
      `HM.o_pins.mux_term = i[0];
      `HM.o_pins.style_code = i[1];
      cyc(5);
      a = 5'h11 + 5'(i * 5);
      d = 8'h3C ^ {3'h0, a};
      `HM.par(1'b0, a, d, rb, fe);
      `CHK(fe, 0)
      `CHK(wr_last, lhp_wr_t'{1'b1, a, d})
      `HM.par(1'b1, a, 8'h00, rb, fe);
      `CHK(fe, 0)
      `CHK(rb, {3'h5, a})
    end
    $display("test parallel done");
    finish_test();
  end
endmodule
